// ===== rtl/fre_pkg.sv
// package for the frontend and retire event counting block
package fre_pkg;
  // event select codes
  localparam logic [11:0] FRE_EV_FETCH_WIN = 12'h080;
  localparam logic [11:0] FRE_EV_FETCH_MISS = 12'h081;
  localparam logic [11:0] FRE_EV_REFILL_L2 = 12'h082;
  localparam logic [11:0] FRE_EV_REFILL_SYS = 12'h083;
  localparam logic [11:0] FRE_EV_ITR_L1MISS = 12'h084;
  localparam logic [11:0] FRE_EV_ITR_L2MISS = 12'h085;
  localparam logic [11:0] FRE_EV_STALL = 12'h087;
  localparam logic [11:0] FRE_EV_BTB1 = 12'h08A;
  localparam logic [11:0] FRE_EV_BTB2 = 12'h08B;
  localparam logic [11:0] FRE_EV_INVAL = 12'h08C;
  localparam logic [11:0] FRE_EV_RELOAD = 12'h099;
  localparam logic [11:0] FRE_EV_SWITCH = 12'h28A;
  localparam logic [11:0] FRE_EV_TOKEN = 12'h0AF;
  localparam logic [11:0] FRE_EV_RET_INSTR = 12'h0C0;
  localparam logic [11:0] FRE_EV_RET_UOPS = 12'h0C1;
  localparam logic [11:0] FRE_EV_RET_BRN = 12'h0C2;
  localparam logic [11:0] FRE_EV_RET_MISP = 12'h0C3;
  localparam logic [11:0] FRE_EV_RET_TKN = 12'h0C4;
  localparam logic [11:0] FRE_EV_RET_TKN_MISP = 12'h0C5;
  localparam logic [11:0] FRE_EV_RET_FAR = 12'h0C6;
  localparam logic [11:0] FRE_EV_RESYNC = 12'h0C7;
  localparam logic [11:0] FRE_EV_NEAR_RET = 12'h0C8;
  localparam logic [11:0] FRE_EV_NEAR_MISP = 12'h0C9;
  localparam logic [11:0] FRE_EV_IND_MISP = 12'h0CA;
  localparam logic [11:0] FRE_EV_MEDIA = 12'h0CB;
  localparam logic [11:0] FRE_EV_COND = 12'h0D1;
  localparam logic [11:0] FRE_EV_DIV_BUSY = 12'h0D3;
  localparam logic [11:0] FRE_EV_DIV_CNT = 12'h0D4;
  localparam logic [11:0] FRE_EV_SAMPLE = 12'h1CF;
  localparam logic [11:0] FRE_EV_FUSED = 12'h1D0;
  // register byte addresses
  localparam logic [7:0] FRE_ADDR_SELECT = 8'h00;
  localparam logic [7:0] FRE_ADDR_COUNT = 8'h04;
  localparam logic [7:0] FRE_ADDR_STATUS = 8'h08;
  // select register fields
  localparam int FRE_SEL_CODE_LSB = 0;
  localparam int FRE_SEL_MASK_LSB = 12;
  localparam int FRE_SEL_EN_BIT = 20;
  localparam logic [31:0] FRE_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] FRE_SEL_WMASK = 32'h001F_FFFF;
  localparam logic [31:0] FRE_CNT_RESET = 32'h0000_0000;
  // per-cycle increment limits
  localparam logic [2:0] FRE_UOPS_MAX = 3'h4;
  localparam logic [2:0] FRE_FUSED_MAX = 3'h3;
endpackage

// ===== rtl/fre_counter.sv
// event selection, unit-mask summing and apb-visible counter
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module fre_counter
  import fre_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_window_delivered,
  input wire logic fetch_window_tag_miss,
  input wire logic icache_refill_from_l2,
  input wire logic icache_refill_from_system,
  input wire logic itrans_first_miss_second_hit,
  input wire logic itrans_both_levels_miss,
  input wire logic stall_any_cause,
  input wire logic stall_decode_queue_empty,
  input wire logic stall_back_pressure,
  input wire logic first_target_buffer_correction,
  input wire logic second_target_buffer_correction,
  input wire logic inval_by_probe,
  input wire logic inval_by_overwriting_fill,
  input wire logic itrans_reload_request,
  input wire logic opcache_to_icache_switch,
  input wire logic icache_to_opcache_switch,
  input wire logic dispatch_group_valid,
  input wire logic retire_token_short,
  input wire logic addrgen_queue_token_short,
  input wire logic alu_total_token_short,
  input wire logic alu_queues_combined_short,
  input wire logic alu_queue_three_short,
  input wire logic alu_queue_two_short,
  input wire logic alu_queue_one_short,
  input wire logic [2:0] retired_instructions,
  input wire logic [2:0] retired_micro_ops,
  input wire logic retired_branches,
  input wire logic retired_branches_mispredicted,
  input wire logic retired_taken_branches,
  input wire logic retired_taken_mispredicted,
  input wire logic retired_far_transfers,
  input wire logic retired_resync_restarts,
  input wire logic retired_near_returns,
  input wire logic near_return_mispredicted,
  input wire logic indirect_branch_mispredicted,
  input wire logic streaming_vector_class,
  input wire logic packed_integer_class,
  input wire logic legacy_stack_float_class,
  input wire logic retired_conditional_branches,
  input wire logic divider_busy_cycles,
  input wire logic divide_op_count,
  input wire logic sample_tagged_ops,
  input wire logic sample_tagged_retired,
  input wire logic sample_tag_blocked,
  input wire logic [1:0] retired_fused_branches,
  output logic [31:0] event_count,
  output logic count_overflow
);

  logic [31:0] select_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic overflow_reg;
  logic [3:0] inc_now;
  logic [2:0] uops_sat;
  logic [1:0] fused_sat;
  logic [11:0] sel_code;
  logic [7:0] sel_mask;
  logic sel_enable;
  logic wr_en;
  logic rd_en;
  logic addr_hit;

  // one-bit sub-event folded into the increment width
  function automatic logic [3:0] fre_bit(input logic b);
    return {3'h0, b};
  endfunction

  // masked sum of up to seven single-bit sub-events
  function automatic logic [3:0] fre_masked(input logic [6:0] ev, input logic [6:0] m);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 7; i++) begin
      s = s + fre_bit(ev[i] & m[i]);
    end
    return s;
  endfunction

  assign sel_code = select_reg[FRE_SEL_CODE_LSB +: 12];
  assign sel_mask = select_reg[FRE_SEL_MASK_LSB +: 8];
  assign sel_enable = select_reg[FRE_SEL_EN_BIT];

  // clamp the micro-op and fused-branch counts to their documented per-cycle ceiling; retired instructions pass unclamped
  assign uops_sat = (retired_micro_ops > FRE_UOPS_MAX) ? FRE_UOPS_MAX : retired_micro_ops;
  assign fused_sat = ({1'b0, retired_fused_branches} > FRE_FUSED_MAX) ?
                     FRE_FUSED_MAX[1:0] : retired_fused_branches;

  // event mux; inputs are raw speculative pulses, nothing filtered at retire
  always_comb begin
    inc_now = 4'h0;
    unique case (sel_code)
      FRE_EV_FETCH_WIN: inc_now = fre_bit(fetch_window_delivered);
      FRE_EV_FETCH_MISS: inc_now = fre_bit(fetch_window_tag_miss);
      FRE_EV_REFILL_L2: inc_now = fre_bit(icache_refill_from_l2);
      FRE_EV_REFILL_SYS: inc_now = fre_bit(icache_refill_from_system);
      FRE_EV_ITR_L1MISS: inc_now = fre_bit(itrans_first_miss_second_hit);
      FRE_EV_ITR_L2MISS: inc_now = fre_bit(itrans_both_levels_miss);
      FRE_EV_STALL: inc_now = fre_masked({4'h0, stall_any_cause,
          stall_decode_queue_empty, stall_back_pressure}, sel_mask[6:0]);
      FRE_EV_BTB1: inc_now = fre_bit(first_target_buffer_correction);
      FRE_EV_BTB2: inc_now = fre_bit(second_target_buffer_correction);
      FRE_EV_INVAL: inc_now = fre_masked({5'h00, inval_by_probe,
          inval_by_overwriting_fill}, sel_mask[6:0]);
      FRE_EV_RELOAD: inc_now = fre_bit(itrans_reload_request);
      FRE_EV_SWITCH: inc_now = fre_masked({5'h00, opcache_to_icache_switch,
          icache_to_opcache_switch}, sel_mask[6:0]);
      // token causes only count while a group is actually waiting
      FRE_EV_TOKEN: inc_now = dispatch_group_valid ? fre_masked({retire_token_short,
          addrgen_queue_token_short, alu_total_token_short, alu_queues_combined_short,
          alu_queue_three_short, alu_queue_two_short, alu_queue_one_short},
          sel_mask[6:0]) : 4'h0;
      FRE_EV_RET_INSTR: inc_now = {1'b0, retired_instructions};
      FRE_EV_RET_UOPS: inc_now = {1'b0, uops_sat};
      FRE_EV_RET_BRN: inc_now = fre_bit(retired_branches);
      FRE_EV_RET_MISP: inc_now = fre_bit(retired_branches_mispredicted);
      FRE_EV_RET_TKN: inc_now = fre_bit(retired_taken_branches);
      FRE_EV_RET_TKN_MISP: inc_now = fre_bit(retired_taken_mispredicted);
      FRE_EV_RET_FAR: inc_now = fre_bit(retired_far_transfers);
      FRE_EV_RESYNC: inc_now = fre_bit(retired_resync_restarts);
      FRE_EV_NEAR_RET: inc_now = fre_bit(retired_near_returns);
      FRE_EV_NEAR_MISP: inc_now = fre_bit(near_return_mispredicted);
      FRE_EV_IND_MISP: inc_now = fre_bit(indirect_branch_mispredicted);
      FRE_EV_MEDIA: inc_now = fre_masked({4'h0, streaming_vector_class,
          packed_integer_class, legacy_stack_float_class}, sel_mask[6:0]);
      FRE_EV_COND: inc_now = fre_bit(retired_conditional_branches);
      FRE_EV_DIV_BUSY: inc_now = fre_bit(divider_busy_cycles);
      FRE_EV_DIV_CNT: inc_now = fre_bit(divide_op_count);
      FRE_EV_SAMPLE: inc_now = fre_masked({4'h0, sample_tag_blocked,
          sample_tagged_retired, sample_tagged_ops}, sel_mask[6:0]);
      FRE_EV_FUSED: inc_now = {2'h0, fused_sat};
      default: inc_now = 4'h0;
    endcase
  end

  // apb decode; zero-wait slave, every access completes in its access phase
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_hit = (paddr == FRE_ADDR_SELECT) || (paddr == FRE_ADDR_COUNT) ||
                    (paddr == FRE_ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // select register, byte lanes honoured; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg <= FRE_SEL_RESET;
    end else if (wr_en && paddr == FRE_ADDR_SELECT) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          select_reg[b*8 +: 8] <= pwdata[b*8 +: 8] & FRE_SEL_WMASK[b*8 +: 8];
        end
      end
    end
  end

  // a software write wins over the increment in the same cycle
  always_comb begin
    count_next = count_reg;
    if (wr_en && paddr == FRE_ADDR_COUNT) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          count_next[b*8 +: 8] = pwdata[b*8 +: 8];
        end
      end
    end else if (sel_enable) begin
      count_next = count_reg + {28'h0, inc_now};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= FRE_CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // sticky wrap flag; a wrap in the clearing cycle keeps it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_reg <= 1'b0;
    end else if (sel_enable && !(wr_en && paddr == FRE_ADDR_COUNT) &&
                 ({1'b0, count_reg} + {29'h0, inc_now} > 33'h0_FFFF_FFFF)) begin
      overflow_reg <= 1'b1;
    end else if (wr_en && paddr == FRE_ADDR_STATUS && pstrb[0] && pwdata[0]) begin
      overflow_reg <= 1'b0;
    end
  end

  // read data registered on the setup phase so it is valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        FRE_ADDR_SELECT: prdata <= select_reg;
        FRE_ADDR_COUNT: prdata <= count_reg;
        FRE_ADDR_STATUS: prdata <= {31'h0, overflow_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign event_count = count_reg;
  assign count_overflow = overflow_reg;

  // micro-op increment never exceeds four
  a_uops_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_enable && sel_code == FRE_EV_RET_UOPS && !wr_en) |=>
    (count_reg - $past(count_reg) <= 32'h4))
    else $error("micro-op increment above four");

  // fused branches add at most three
  a_fused_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_enable && sel_code == FRE_EV_FUSED && !wr_en) |=>
    (count_reg - $past(count_reg) <= 32'h3))
    else $error("fused increment above three");

  // all-zero mask on the stall event leaves the count still
  a_zero_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_code == FRE_EV_STALL && sel_mask == 8'h00 && !wr_en) |=>
    (count_reg == $past(count_reg)))
    else $error("zero mask still counted");

  // fetch window pulse adds exactly one
  a_fetch_win: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_enable && sel_code == FRE_EV_FETCH_WIN && fetch_window_delivered && !wr_en) |=>
    (count_reg == $past(count_reg) + 32'h1))
    else $error("fetch window not counted");

  // stall with both top causes enabled adds two
  a_stall_two: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_enable && sel_code == FRE_EV_STALL && sel_mask[2:0] == 3'h6 &&
     stall_any_cause && stall_decode_queue_empty && !wr_en) |=>
    (count_reg == $past(count_reg) + 32'h2))
    else $error("stall causes not summed");

  // no token stall counted without a valid group
  a_token_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_code == FRE_EV_TOKEN && !dispatch_group_valid && !wr_en) |=>
    $stable(count_reg))
    else $error("token stall counted without group");

  // probe invalidation counted only with its mask bit
  a_inval_probe: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_enable && sel_code == FRE_EV_INVAL && sel_mask[1:0] == 2'h2 && inval_by_probe &&
     !wr_en) |=> (count_reg == $past(count_reg) + 32'h1))
    else $error("probe invalidation missed");

  // taken mispredict adds one
  a_taken_misp: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_enable && sel_code == FRE_EV_RET_TKN_MISP && retired_taken_mispredicted && !wr_en)
    |=> (count_reg == $past(count_reg) + 32'h1))
    else $error("taken mispredict missed");

endmodule

// ===== verif/tb_frontend_retire_event_counting.sv
// self-checking bench for the event selection and counter block
`timescale 1ns/100ps
module tb_frontend_retire_event_counting
  import fre_pkg::*;
;
  localparam logic [41:0] ALL = {42{1'b1}};
  localparam logic [31:0] EN = 32'h0010_0000;
  // single-occurrence events and the bench vector bit that carries each
  localparam logic [11:0] SCODE [21] = '{FRE_EV_FETCH_WIN, FRE_EV_FETCH_MISS, FRE_EV_REFILL_L2,
    FRE_EV_REFILL_SYS, FRE_EV_ITR_L1MISS, FRE_EV_ITR_L2MISS, FRE_EV_BTB1, FRE_EV_BTB2,
    FRE_EV_RELOAD, FRE_EV_RET_BRN, FRE_EV_RET_MISP, FRE_EV_RET_TKN, FRE_EV_RET_TKN_MISP,
    FRE_EV_RET_FAR, FRE_EV_RESYNC, FRE_EV_NEAR_RET, FRE_EV_NEAR_MISP, FRE_EV_IND_MISP,
    FRE_EV_COND, FRE_EV_DIV_BUSY, FRE_EV_DIV_CNT};
  localparam int SBIT [21] = '{0, 1, 2, 3, 4, 5, 9, 10, 13, 24, 25, 26, 27, 28, 29, 30, 31, 32,
    36, 37, 38};
  // masked events: mask bit k is carried by vector bit top minus k
  localparam logic [11:0] MCODE [6] = '{FRE_EV_STALL, FRE_EV_INVAL, FRE_EV_SWITCH, FRE_EV_TOKEN,
    FRE_EV_MEDIA, FRE_EV_SAMPLE};
  localparam int MTOP [6] = '{8, 12, 15, 23, 35, 41};
  localparam int MW [6] = '{3, 2, 2, 7, 3, 3};
  localparam logic [7:0] MMASK [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [41:0] ev = '0; // one bit per single-bit event input
  logic [7:0] mb = 8'h00; // {retired instr, micro-ops, fused branches}
  logic [31:0] event_count;
  logic count_overflow;
  int fails = 0;
  int checked = 0;

  // 250 MHz core clock
  always #2 pclk = ~pclk;

  fre_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch_window_delivered(ev[0]),
    .fetch_window_tag_miss(ev[1]), .icache_refill_from_l2(ev[2]),
    .icache_refill_from_system(ev[3]), .itrans_first_miss_second_hit(ev[4]),
    .itrans_both_levels_miss(ev[5]), .stall_any_cause(ev[6]), .stall_decode_queue_empty(ev[7]),
    .stall_back_pressure(ev[8]), .first_target_buffer_correction(ev[9]),
    .second_target_buffer_correction(ev[10]), .inval_by_probe(ev[11]),
    .inval_by_overwriting_fill(ev[12]), .itrans_reload_request(ev[13]),
    .opcache_to_icache_switch(ev[14]), .icache_to_opcache_switch(ev[15]),
    .dispatch_group_valid(ev[16]), .retire_token_short(ev[17]),
    .addrgen_queue_token_short(ev[18]), .alu_total_token_short(ev[19]),
    .alu_queues_combined_short(ev[20]), .alu_queue_three_short(ev[21]),
    .alu_queue_two_short(ev[22]), .alu_queue_one_short(ev[23]),
    .retired_instructions(mb[7:5]), .retired_micro_ops(mb[4:2]), .retired_branches(ev[24]),
    .retired_branches_mispredicted(ev[25]), .retired_taken_branches(ev[26]),
    .retired_taken_mispredicted(ev[27]), .retired_far_transfers(ev[28]),
    .retired_resync_restarts(ev[29]), .retired_near_returns(ev[30]),
    .near_return_mispredicted(ev[31]), .indirect_branch_mispredicted(ev[32]),
    .streaming_vector_class(ev[33]), .packed_integer_class(ev[34]),
    .legacy_stack_float_class(ev[35]), .retired_conditional_branches(ev[36]),
    .divider_busy_cycles(ev[37]), .divide_op_count(ev[38]), .sample_tag_blocked(ev[39]),
    .sample_tagged_retired(ev[40]), .sample_tagged_ops(ev[41]),
    .retired_fused_branches(mb[1:0]), .event_count(event_count),
    .count_overflow(count_overflow));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; waits on pready, never on a fixed count
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never reassigns in this time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
    input logic experr = 1'b0);
    logic [31:0] rd;
    logic e;
    xfer(1'b1, a, d, s, rd, e);
    chk("write slave error", {31'h0, experr}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name,
    input logic experr = 1'b0);
    logic [31:0] rd;
    logic e;
    xfer(1'b0, a, 32'h0, 4'h0, rd, e);
    chk(name, exp, rd);
    chk("read slave error", {31'h0, experr}, {31'h0, e});
  endtask

  // two cycles of distractor traffic, then three cycles of the counted pattern
  task automatic run_case(input logic [11:0] code, input logic [7:0] mask,
    input logic [41:0] poff, input logic [7:0] mboff, input logic [41:0] pon,
    input logic [7:0] mbon, input logic [31:0] exp);
    wr(FRE_ADDR_SELECT, EN | {12'h0, mask, code});
    wr(FRE_ADDR_COUNT, 32'h0);
    ev <= poff;
    mb <= mboff;
    repeat (2) @(posedge pclk);
    ev <= pon;
    mb <= mbon;
    repeat (3) @(posedge pclk);
    ev <= '0;
    mb <= 8'h00;
    rd_chk(FRE_ADDR_COUNT, exp, $sformatf("count of code %h mask %h", code, mask));
    chk("event_count port", exp, event_count);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about eight hundred cycles
  initial begin
    repeat (8000) @(posedge pclk);
    fails++;
    $display("MISMATCH watchdog expected completion seen hang");
    summarize();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("event_count after reset", FRE_CNT_RESET, event_count);
    rd_chk(FRE_ADDR_SELECT, FRE_SEL_RESET, "select after reset");
    rd_chk(FRE_ADDR_COUNT, FRE_CNT_RESET, "count after reset");
    rd_chk(FRE_ADDR_STATUS, 32'h0, "status after reset");
    wr(FRE_ADDR_SELECT, 32'hFFFF_FFFF);
    rd_chk(FRE_ADDR_SELECT, FRE_SEL_WMASK, "select writable bits");
    // unmapped word: write dropped, read zero, error flagged
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd_chk(8'h0C, 32'h0, "unmapped read", 1'b1);
    // each single event counted alone after two cycles with every other input busy and it idle
    for (int i = 0; i < 21; i++) begin
      run_case(SCODE[i], 8'h00, ~(42'h1 << SBIT[i]), 8'hFF, 42'h1 << SBIT[i], 8'h00, 32'h3);
    end
    // masked events: every enabled sub-event adds, disabled ones and mask bit 7 do not
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        logic [41:0] r;
        logic [31:0] e;
        r = '0;
        for (int k = 0; k < MW[i]; k++) r[MTOP[i] - k] = 1'b1;
        e = 32'(3 * $countones(MMASK[j] & ((8'h1 << MW[i]) - 8'h1)));
        run_case(MCODE[i], MMASK[j], ~r, 8'hFF, ALL, 8'hFF, e);
      end
    end
    // token stalls only count while a dispatch group is valid
    run_case(FRE_EV_TOKEN, 8'hFF, ALL & ~(42'h1 << 16), 8'h00, ALL & ~(42'h1 << 16), 8'h00, 32'h0);
    run_case(FRE_EV_RET_UOPS, 8'h00, ALL, 8'hA3, ALL, 8'h10, 32'h0000_000C);
    run_case(FRE_EV_RET_UOPS, 8'h00, ALL, 8'hA3, ALL, 8'h1C, 32'h0000_000C);
    run_case(FRE_EV_FUSED, 8'h00, ALL, 8'hB0, ALL, 8'h03, 32'h9);
    run_case(FRE_EV_RET_INSTR, 8'h00, ALL, 8'h13, ALL, 8'hA0, 32'hF);
    run_case(12'h0FF, 8'hFF, ALL, 8'hFF, ALL, 8'hFF, 32'h0);
    // wrap sets the sticky flag; write one clears it
    wr(FRE_ADDR_SELECT, EN | {20'h0, FRE_EV_FETCH_WIN});
    wr(FRE_ADDR_COUNT, 32'hFFFF_FFFE);
    ev <= 42'h1;
    repeat (3) @(posedge pclk);
    ev <= '0;
    rd_chk(FRE_ADDR_COUNT, 32'h1, "count after wrap");
    chk("overflow flag", 32'h1, {31'h0, count_overflow});
    rd_chk(FRE_ADDR_STATUS, 32'h1, "status after wrap");
    wr(FRE_ADDR_STATUS, 32'h1, 4'h1);
    rd_chk(FRE_ADDR_STATUS, 32'h0, "status after clear");
    chk("overflow flag cleared", 32'h0, {31'h0, count_overflow});
    // only the strobed byte lanes of the counter change
    wr(FRE_ADDR_COUNT, 32'h1234_5678, 4'h3);
    rd_chk(FRE_ADDR_COUNT, 32'h0000_5678, "count byte lanes");
    summarize();
  end
endmodule
